// *** core/pin_irq_block.sv ***
// Purpose: Port input mode, pull select, pad drive and pin-change interrupts.
// Assumes: Single clock; pin inputs synchronous to it but still double-sampled.
// Notes: Port requests also feed a summary status register for one interrupt line.
`timescale 1ns/1ps
module pin_irq_block (
  input wire logic clock, // 40 MHz system clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [31:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error for unmapped address
  input wire logic [7:0] port0_in, // Port 0 pin levels
  input wire logic [7:0] port1_in, // Port 1 pin levels
  input wire logic [4:0] port2_in, // Port 2 pin levels
  output logic [7:0] port1_tristate, // Port 1 tristate per pin
  output logic [4:0] port2_tristate, // Port 2 tristate per pin
  output logic port0_pull_down_sel, // Port 0 pull-down select
  output logic port1_pull_down_sel, // Port 1 pull-down select
  output logic port2_pull_down_sel, // Port 2 pull-down select
  output logic pad_drive_max, // Maximum pad drive
  output logic port0_irq, // Port 0 request level
  output logic port1_irq, // Port 1 request level
  output logic port2_irq, // Port 2 request level
  output logic irq // Summary interrupt, level
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] port1_input_mode_reg;
  logic [7:0] port2_input_mode_reg;
  logic [7:0] pin_irq_control_reg;
  logic [7:0] port1_pin_irq_mask_reg;
  logic [7:0] port0_pending;
  logic [7:0] port1_pending;
  logic [4:0] port2_pending;
  logic [2:0] irq_status;
  logic [2:0] irq_enable;
  logic [20:0] sync_a;
  logic [20:0] sync_b;
  logic [20:0] sync_prev;
  // The compare stage holds no real sample until three edges after reset;
  // without this gate a pin resting high would look like a rising edge
  logic [1:0] fill;
  wire sync_ready = (fill == 2'h3);
  logic [7:0] rd_byte;
  logic [7:0] next_port0_pending;
  logic [7:0] next_port1_pending;
  logic [4:0] next_port2_pending;

  function automatic logic [7:0] edges(input logic [7:0] cur, input logic [7:0] prev,
                                       input logic falling);
    edges = falling ? (prev & ~cur) : (cur & ~prev);
  endfunction

  function automatic logic [7:0] keep_or_clear(input logic [7:0] flags, input logic [7:0] wd,
                                               input logic hit);
    keep_or_clear = hit ? (flags & wd) : flags;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; zero wait states, always ready
  wire access = psel && penable;
  wire [7:0] idx = paddr[9:2];
  wire aligned = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h0);
  wire [7:0] wd = pwdata[7:0];
  wire hit_p0f = aligned && idx == pin_irq_pkg::IDX_PORT0_FLAG;
  wire hit_p1f = aligned && idx == pin_irq_pkg::IDX_PORT1_FLAG;
  wire hit_p2f = aligned && idx == pin_irq_pkg::IDX_PORT2_FLAG;
  wire hit_ctl = aligned && idx == pin_irq_pkg::IDX_PIN_IRQ_CONTROL;
  wire hit_msk = aligned && idx == pin_irq_pkg::IDX_PORT1_IRQ_MASK;
  wire hit_m1 = aligned && idx == pin_irq_pkg::IDX_PORT1_INPUT_MODE;
  wire hit_m2 = aligned && idx == pin_irq_pkg::IDX_PORT2_INPUT_MODE;
  wire hit_st = aligned && idx == pin_irq_pkg::IDX_IRQ_STATUS;
  wire hit_clr = aligned && idx == pin_irq_pkg::IDX_IRQ_CLEAR;
  wire hit_en = aligned && idx == pin_irq_pkg::IDX_IRQ_ENABLE;
  wire mapped = hit_p0f | hit_p1f | hit_p2f | hit_ctl | hit_msk | hit_m1 | hit_m2
              | hit_st | hit_clr | hit_en;
  wire wr = access && pwrite && mapped;

  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  assign rd_byte = hit_p0f ? port0_pending :
                   hit_p1f ? port1_pending :
                   hit_p2f ? {3'h0, port2_pending} :
                   hit_ctl ? pin_irq_control_reg :
                   hit_msk ? port1_pin_irq_mask_reg :
                   hit_m1 ? port1_input_mode_reg :
                   hit_m2 ? port2_input_mode_reg :
                   hit_st ? {5'h0, irq_status} :
                   hit_en ? {5'h0, irq_enable} : 8'h00;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) prdata <= 32'h0;
    else if (psel && !penable && !pwrite) prdata <= {24'h0, rd_byte};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      port1_input_mode_reg <= pin_irq_pkg::RESET_VALUE;
      port2_input_mode_reg <= pin_irq_pkg::RESET_VALUE;
      pin_irq_control_reg <= pin_irq_pkg::RESET_VALUE;
      port1_pin_irq_mask_reg <= pin_irq_pkg::RESET_VALUE;
      irq_enable <= 3'h0;
    end else if (wr) begin
      if (hit_m1) port1_input_mode_reg <= wd & pin_irq_pkg::PORT1_MODE_MASK;
      if (hit_m2) port2_input_mode_reg <= wd;
      if (hit_ctl) pin_irq_control_reg <= wd & pin_irq_pkg::CONTROL_MASK;
      if (hit_msk) port1_pin_irq_mask_reg <= wd;
      if (hit_en) irq_enable <= wd[2:0];
    end
  end

  assign port1_tristate = port1_input_mode_reg;
  assign port2_tristate = port2_input_mode_reg[4:0];
  assign port0_pull_down_sel = port2_input_mode_reg[pin_irq_pkg::BIT_PORT0_PULL_DOWN];
  assign port1_pull_down_sel = port2_input_mode_reg[pin_irq_pkg::BIT_PORT1_PULL_DOWN];
  assign port2_pull_down_sel = port2_input_mode_reg[pin_irq_pkg::BIT_PORT2_PULL_DOWN];
  assign pad_drive_max = pin_irq_control_reg[pin_irq_pkg::BIT_PAD_DRIVE_MAX];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; sync_a is read only by sync_b
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync_a <= 21'h0;
      sync_b <= 21'h0;
      sync_prev <= 21'h0;
      fill <= 2'h0;
    end else begin
      sync_a <= {port2_in, port1_in, port0_in};
      sync_b <= sync_a;
      sync_prev <= sync_b;
      if (!sync_ready) fill <= fill + 2'h1;
    end
  end

  wire [7:0] edge0 = {8{sync_ready}} & edges(sync_b[7:0], sync_prev[7:0],
                           pin_irq_control_reg[pin_irq_pkg::BIT_PORT0_FALLING]);
  wire [7:0] edge1 = {8{sync_ready}} & edges(sync_b[15:8], sync_prev[15:8],
                           pin_irq_control_reg[pin_irq_pkg::BIT_PORT1_FALLING]);
  wire [7:0] edge2 = {8{sync_ready}} & edges({3'h0, sync_b[20:16]}, {3'h0, sync_prev[20:16]},
                           pin_irq_control_reg[pin_irq_pkg::BIT_PORT2_FALLING]);

  // Set after clear so a same-cycle edge survives the write
  assign next_port0_pending = keep_or_clear(port0_pending, wd, wr && hit_p0f) | edge0;
  assign next_port1_pending = keep_or_clear(port1_pending, wd, wr && hit_p1f) | edge1;
  wire [7:0] p2_kept = keep_or_clear({3'h0, port2_pending}, wd, wr && hit_p2f);
  assign next_port2_pending = p2_kept[4:0] | edge2[4:0];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      port0_pending <= 8'h00;
      port1_pending <= 8'h00;
      port2_pending <= 5'h00;
    end else begin
      port0_pending <= next_port0_pending;
      port1_pending <= next_port1_pending;
      port2_pending <= next_port2_pending;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port requests and summary interrupt
  wire p0_hi_en = pin_irq_control_reg[pin_irq_pkg::BIT_PORT0_UPPER_IRQ_EN];
  wire p0_lo_en = pin_irq_control_reg[pin_irq_pkg::BIT_PORT0_LOWER_IRQ_EN];
  wire p2_en = pin_irq_control_reg[pin_irq_pkg::BIT_PORT2_GROUP_IRQ_EN];
  assign port0_irq = (p0_hi_en && |port0_pending[7:4]) || (p0_lo_en && |port0_pending[3:0]);
  assign port1_irq = |(port1_pending & port1_pin_irq_mask_reg);
  assign port2_irq = p2_en && |port2_pending;

  // Sticky summary bits; a rising request wins over a clear in the same cycle
  logic [2:0] req_prev;
  wire [2:0] req_now = {port2_irq, port1_irq, port0_irq};
  wire [2:0] req_rise = req_now & ~req_prev;
  wire [2:0] clr_bits = (wr && hit_clr) ? wd[2:0] : 3'h0;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      req_prev <= 3'h0;
      irq_status <= 3'h0;
    end else begin
      req_prev <= req_now;
      irq_status <= (irq_status & ~clr_bits) | req_rise;
    end
  end

  assign irq = |(irq_status & irq_enable);

  ////////////////////////////////////////////////////////////////////////////
  // Mode, pull and drive registers
  AST_P1_LOW_ZERO: assert property (@(posedge clock) disable iff (!nrst)
    port1_input_mode_reg[1:0] == 2'b00) else $error("port1 mode low bits set");

  AST_P1_WRITE: assert property (@(posedge clock) disable iff (!nrst)
    wr && hit_m1 |=> port1_input_mode_reg == ($past(wd) & pin_irq_pkg::PORT1_MODE_MASK))
    else $error("port1 mode write wrong");

  AST_P1_TRI_OUT: assert property (@(posedge clock) disable iff (!nrst)
    port1_tristate[1:0] == 2'b00)
    else $error("port1 low pins tristate");

  AST_P2_TRI: assert property (@(posedge clock) disable iff (!nrst)
    wr && hit_m2 |=> port2_tristate == $past(wd[4:0])) else $error("port2 mode lost");

  AST_P2_MODE_KEEP: assert property (@(posedge clock) disable iff (!nrst)
    !(wr && hit_m2) |=> $stable(port2_input_mode_reg))
    else $error("port2 mode changed without write");

  AST_PULL: assert property (@(posedge clock) disable iff (!nrst)
    wr && hit_m2 |=> port1_pull_down_sel == $past(wd[6])) else $error("pull select wrong");

  AST_PULL0: assert property (@(posedge clock) disable iff (!nrst)
    wr && hit_m2 |=> port0_pull_down_sel == $past(wd[5]))
    else $error("port0 pull select wrong");

  AST_PULL2: assert property (@(posedge clock) disable iff (!nrst)
    wr && hit_m2 |=> port2_pull_down_sel == $past(wd[7]))
    else $error("port2 pull select wrong");

  AST_CTL7: assert property (@(posedge clock) disable iff (!nrst)
    pin_irq_control_reg[7] == 1'b0) else $error("control bit 7 set");

  AST_CTL_WRITE: assert property (@(posedge clock) disable iff (!nrst)
    wr && hit_ctl |=> pin_irq_control_reg == ($past(wd) & pin_irq_pkg::CONTROL_MASK))
    else $error("control write wrong");

  AST_PAD: assert property (@(posedge clock) disable iff (!nrst)
    wr && hit_ctl |=> pad_drive_max == $past(wd[6]))
    else $error("pad drive wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Pending flags
  AST_P0_SET: assert property (@(posedge clock) disable iff (!nrst)
    |edge0 |=> (port0_pending & $past(edge0)) == $past(edge0)) else $error("p0 edge lost");

  AST_P0_CLEAR: assert property (@(posedge clock) disable iff (!nrst)
    wr && hit_p0f && edge0 == 8'h00 |=> port0_pending == ($past(port0_pending) & $past(wd)))
    else $error("p0 clear wrong");

  AST_P0_HOLD: assert property (@(posedge clock) disable iff (!nrst)
    !(wr && hit_p0f) |=> (port0_pending & $past(port0_pending)) == $past(port0_pending))
    else $error("p0 flag dropped without write");

  AST_P1_CLEAR: assert property (@(posedge clock) disable iff (!nrst)
    wr && hit_p1f && edge1 == 8'h00 |=> port1_pending == ($past(port1_pending) & $past(wd)))
    else $error("p1 clear wrong");

  AST_P1_SET: assert property (@(posedge clock) disable iff (!nrst)
    |edge1 |=> (port1_pending & $past(edge1)) == $past(edge1))
    else $error("p1 edge lost");

  AST_P1_HOLD: assert property (@(posedge clock) disable iff (!nrst)
    !(wr && hit_p1f) |=> (port1_pending & $past(port1_pending)) == $past(port1_pending))
    else $error("p1 flag dropped without write");

  AST_P2_HIGH: assert property (@(posedge clock) disable iff (!nrst)
    psel && !penable && !pwrite && hit_p2f |=> prdata[7:5] == 3'b000)
    else $error("p2 high bits read set");

  AST_P2_SET: assert property (@(posedge clock) disable iff (!nrst)
    |edge2[4:0] |=> (port2_pending & $past(edge2[4:0])) == $past(edge2[4:0]))
    else $error("p2 edge lost");

  AST_P2_CLEAR: assert property (@(posedge clock) disable iff (!nrst)
    wr && hit_p2f && edge2 == 8'h00 |=> port2_pending == ($past(port2_pending) & $past(wd[4:0])))
    else $error("p2 clear wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Port requests
  AST_P2_IRQ: assert property (@(posedge clock) disable iff (!nrst)
    !p2_en |-> !port2_irq) else $error("port2 irq while disabled");

  AST_P2_IRQ_ON: assert property (@(posedge clock) disable iff (!nrst)
    p2_en && |port2_pending |-> port2_irq)
    else $error("port2 irq missing");

  AST_P0_HI: assert property (@(posedge clock) disable iff (!nrst)
    p0_hi_en && |port0_pending[7:4] |-> port0_irq) else $error("p0 upper irq missing");

  AST_P0_HI_OFF: assert property (@(posedge clock) disable iff (!nrst)
    !p0_hi_en && port0_pending[3:0] == 4'h0 |-> !port0_irq)
    else $error("p0 upper irq while disabled");

  AST_P0_LO: assert property (@(posedge clock) disable iff (!nrst)
    !p0_hi_en && !p0_lo_en |-> !port0_irq) else $error("p0 irq while disabled");

  AST_P0_LO_ON: assert property (@(posedge clock) disable iff (!nrst)
    p0_lo_en && |port0_pending[3:0] |-> port0_irq)
    else $error("p0 lower irq missing");

  AST_P0_LO_OFF: assert property (@(posedge clock) disable iff (!nrst)
    !p0_lo_en && port0_pending[7:4] == 4'h0 |-> !port0_irq)
    else $error("p0 lower irq while disabled");

  AST_MASK1: assert property (@(posedge clock) disable iff (!nrst)
    port1_pin_irq_mask_reg == 8'h00 |-> !port1_irq) else $error("p1 irq while masked");

  AST_MASK1_ON: assert property (@(posedge clock) disable iff (!nrst)
    |(port1_pending & port1_pin_irq_mask_reg) |-> port1_irq)
    else $error("p1 irq missing");

  AST_MASK_WRITE: assert property (@(posedge clock) disable iff (!nrst)
    wr && hit_msk |=> port1_pin_irq_mask_reg == $past(wd))
    else $error("p1 mask write wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Edge selection and synchroniser
  AST_RISE1: assert property (@(posedge clock) disable iff (!nrst)
    !pin_irq_control_reg[1] && sync_ready && $rose(sync_b[8]) |=> port1_pending[0])
    else $error("p1 rising edge missed");

  AST_FALL1: assert property (@(posedge clock) disable iff (!nrst)
    pin_irq_control_reg[1] && sync_ready && $fell(sync_b[8]) |=> port1_pending[0])
    else $error("p1 falling edge missed");

  AST_FALL2: assert property (@(posedge clock) disable iff (!nrst)
    pin_irq_control_reg[2] && sync_ready && $fell(sync_b[16]) |=> port2_pending[0])
    else $error("p2 falling edge missed");

  AST_RISE2: assert property (@(posedge clock) disable iff (!nrst)
    !pin_irq_control_reg[2] && sync_ready && $rose(sync_b[16]) |=> port2_pending[0])
    else $error("p2 rising edge missed");

  AST_FALL0: assert property (@(posedge clock) disable iff (!nrst)
    pin_irq_control_reg[0] && $rose(sync_b[0]) && !port0_pending[0] |=> !port0_pending[0])
    else $error("p0 rising edge flagged in falling mode");

  AST_RISE0: assert property (@(posedge clock) disable iff (!nrst)
    !pin_irq_control_reg[0] && sync_ready && $rose(sync_b[0]) |=> port0_pending[0])
    else $error("p0 rising edge missed");

  AST_SYNC: assert property (@(posedge clock) disable iff (!nrst)
    !pin_irq_control_reg[0] && sync_ready && $rose(port0_in[3]) ##1 port0_in[3] ##1 1'b1
    |=> port0_pending[3]) else $error("synchronised edge missed");

  AST_WARM: assert property (@(posedge clock) disable iff (!nrst)
    !sync_ready |-> edge0 == 8'h00 && edge1 == 8'h00 && edge2 == 8'h00)
    else $error("edge seen before synchroniser filled");

  AST_SET_WINS: assert property (@(posedge clock) disable iff (!nrst)
    wr && hit_p0f && edge0[0] |=> port0_pending[0]) else $error("set lost to clear");

  AST_SET_WINS1: assert property (@(posedge clock) disable iff (!nrst)
    wr && hit_p1f && edge1[0] |=> port1_pending[0])
    else $error("p1 set lost to clear");

  AST_WRITE_ONE: assert property (@(posedge clock) disable iff (!nrst)
    wr && hit_p1f && wd == 8'hff |=> (port1_pending & $past(port1_pending)) == $past(port1_pending))
    else $error("writing one dropped a flag");

  ////////////////////////////////////////////////////////////////////////////
  // Main scenarios
  COV_P0_EDGE: cover property (@(posedge clock) disable iff (!nrst) |edge0);
  COV_CLEAR: cover property (@(posedge clock) disable iff (!nrst) wr && hit_p1f);
  COV_IRQ: cover property (@(posedge clock) disable iff (!nrst) $rose(irq));
  COV_P2_FALL: cover property (@(posedge clock) disable iff (!nrst)
    pin_irq_control_reg[2] && |edge2);
  COV_P2_IRQ: cover property (@(posedge clock) disable iff (!nrst) $rose(port2_irq));
endmodule

// *** core/pin_irq_pkg.sv ***
// Purpose: Constants for the port input mode and pin interrupt block.
// Assumes: APB with 32-bit data, each register one word.
// Notes: Register indices are printed offsets; byte address is four times the index.
package pin_irq_pkg;
  localparam logic [7:0] IDX_PORT0_FLAG = 8'h89;
  localparam logic [7:0] IDX_PORT1_FLAG = 8'h8a;
  localparam logic [7:0] IDX_PORT2_FLAG = 8'h8b;
  localparam logic [7:0] IDX_PIN_IRQ_CONTROL = 8'h8c;
  localparam logic [7:0] IDX_PORT1_IRQ_MASK = 8'h8d;
  localparam logic [7:0] IDX_PORT1_INPUT_MODE = 8'hf6;
  localparam logic [7:0] IDX_PORT2_INPUT_MODE = 8'hf7;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hc0;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'hc1;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'hc2;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] PORT1_MODE_MASK = 8'hfc;
  localparam logic [7:0] PORT2_FLAG_MASK = 8'h1f;
  localparam logic [7:0] CONTROL_MASK = 8'h7f;
  localparam int BIT_PORT2_PULL_DOWN = 7;
  localparam int BIT_PORT1_PULL_DOWN = 6;
  localparam int BIT_PORT0_PULL_DOWN = 5;
  localparam int BIT_PAD_DRIVE_MAX = 6;
  localparam int BIT_PORT2_GROUP_IRQ_EN = 5;
  localparam int BIT_PORT0_UPPER_IRQ_EN = 4;
  localparam int BIT_PORT0_LOWER_IRQ_EN = 3;
  localparam int BIT_PORT2_FALLING = 2;
  localparam int BIT_PORT1_FALLING = 1;
  localparam int BIT_PORT0_FALLING = 0;
endpackage

// *** verification/pin_model.sv ***
// Purpose: Pin-side model that drives the three ports' input levels.
// Assumes: Driven levels and the port 1 float mask come from the bench.
// Notes: A released pin never keeps its last level: pulled pins follow the pull.
`timescale 1ns/1ps
module pin_model (
  input wire logic clock, // System clock
  input wire logic [7:0] drv0, // Port 0 driven levels
  input wire logic [7:0] drv1, // Port 1 driven levels
  input wire logic [4:0] drv2, // Port 2 driven levels
  input wire logic [7:0] float1, // Port 1 pins left undriven
  input wire logic [7:0] port1_tristate, // Port 1 tristate per pin
  input wire logic port1_pull_down_sel, // Port 1 pull-down select
  output logic [7:0] port0_in, // Port 0 pin levels
  output logic [7:0] port1_in, // Port 1 pin levels
  output logic [4:0] port2_in // Port 2 pin levels
);
  logic wander = 1'b0;
  always @(posedge clock) wander <= ~wander;
  assign port0_in = drv0;
  assign port2_in = drv2;
  // Floating tristate pins wander so an unknown never settles to a friendly value
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!float1[i]) port1_in[i] = drv1[i];
      else if (port1_tristate[i]) port1_in[i] = wander;
      else port1_in[i] = ~port1_pull_down_sel;
    end
  end
endmodule

// *** verification/tb_top.sv ***
// Purpose: Self-checking bench for the port mode and pin interrupt block.
// Assumes: Zero-wait APB slave; pin edges show in flags three edges later.
// Notes: Expected values come from the register layout, never from the design.
`timescale 1ns/1ps
module tb_top;
  logic clock, nrst, psel, penable, pwrite, pready, pslverr, slv;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [7:0] drv0, drv1, float1, port0_in, port1_in, port1_tristate;
  logic [4:0] drv2, port2_in, port2_tristate;
  logic port0_pull_down_sel, port1_pull_down_sel, port2_pull_down_sel, pad_drive_max;
  logic port0_irq, port1_irq, port2_irq, irq;
  int miscompares, tests_run;
  localparam logic [7:0] F0 = pin_irq_pkg::IDX_PORT0_FLAG;
  localparam logic [7:0] F1 = pin_irq_pkg::IDX_PORT1_FLAG;
  localparam logic [7:0] F2 = pin_irq_pkg::IDX_PORT2_FLAG;
  localparam logic [7:0] CT = pin_irq_pkg::IDX_PIN_IRQ_CONTROL;
  localparam logic [7:0] M1 = pin_irq_pkg::IDX_PORT1_INPUT_MODE;
  localparam logic [7:0] M2 = pin_irq_pkg::IDX_PORT2_INPUT_MODE;
  localparam logic [7:0] MK = pin_irq_pkg::IDX_PORT1_IRQ_MASK;
  logic [7:0] regs [8] = '{F0, F1, F2, CT, M1, M2, MK, pin_irq_pkg::IDX_IRQ_ENABLE};
  pin_irq_block pin_irq_block_inst (.clock(clock), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port0_in(port0_in), .port1_in(port1_in),
    .port2_in(port2_in), .port1_tristate(port1_tristate), .port2_tristate(port2_tristate),
    .port0_pull_down_sel(port0_pull_down_sel), .port1_pull_down_sel(port1_pull_down_sel),
    .port2_pull_down_sel(port2_pull_down_sel), .pad_drive_max(pad_drive_max),
    .port0_irq(port0_irq), .port1_irq(port1_irq), .port2_irq(port2_irq), .irq(irq));
  pin_model pin_model_inst (.clock(clock), .drv0(drv0), .drv1(drv1), .drv2(drv2),
    .float1(float1), .port1_tristate(port1_tristate),
    .port1_pull_down_sel(port1_pull_down_sel), .port0_in(port0_in), .port1_in(port1_in),
    .port2_in(port2_in));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Holds the request until pready is seen high, then releases it
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input string what);
    apb(1'b0, idx, 8'h00);
    chk(what, {24'h0, exp}, rd);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #(25ns * 6000);
    miscompares++;
    finish_test();
  end
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {drv0, drv1, drv2, float1, miscompares, tests_run} = '0;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    foreach (regs[i]) rdchk(regs[i], 8'h00, "reset value");
    apb(1'b1, M1, 8'hff);
    rdchk(M1, 8'hfc, "port1 mode");
    apb(1'b1, M2, 8'h40);
    rdchk(M2, 8'h40, "port2 mode");
    @(negedge clock);
    chk("port1 tristate", 32'hfc, {24'h0, port1_tristate});
    chk("pulls", 32'h40, {24'h0, port2_pull_down_sel, port1_pull_down_sel,
      port0_pull_down_sel, port2_tristate});
    apb(1'b1, M1, 8'h00);
    apb(1'b1, M2, 8'h00);
    float1 <= 8'h04;
    repeat (4) @(posedge clock);
    rdchk(F1, 8'h04, "port1 flags pulled up");
    apb(1'b1, F1, 8'hfb);
    rdchk(F1, 8'h00, "port1 flags cleared");
    apb(1'b1, CT, 8'h02);
    apb(1'b1, M2, 8'h40);
    repeat (4) @(posedge clock);
    rdchk(F1, 8'h04, "port1 falling");
    apb(1'b1, MK, 8'h04);
    @(negedge clock);
    chk("port1 irq", 32'h1, {31'h0, port1_irq});
    apb(1'b1, pin_irq_pkg::IDX_IRQ_ENABLE, 8'h01);
    drv0 <= 8'h11;
    repeat (4) @(posedge clock);
    rdchk(F0, 8'h11, "port0 rising");
    chk("port0 irq off", 32'h0, {31'h0, port0_irq});
    apb(1'b1, CT, 8'h0a);
    @(negedge clock);
    chk("port0 irq lower", 32'h1, {31'h0, port0_irq});
    repeat (3) @(negedge clock);
    chk("irq line", 32'h1, {31'h0, irq});
    rdchk(pin_irq_pkg::IDX_IRQ_STATUS, 8'h03, "irq status");
    apb(1'b1, F0, 8'hff);
    rdchk(F0, 8'h11, "port0 write one");
    apb(1'b1, F0, 8'hef);
    drv0 <= 8'h00;
    repeat (4) @(posedge clock);
    rdchk(F0, 8'h01, "port0 partial clear");
    apb(1'b1, CT, 8'h12);
    @(negedge clock);
    chk("port0 irq upper", 32'h0, {31'h0, port0_irq});
    apb(1'b1, pin_irq_pkg::IDX_IRQ_CLEAR, 8'h01);
    @(negedge clock);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(1'b1, CT, 8'h24);
    drv2 <= 5'h1f;
    repeat (4) @(posedge clock);
    rdchk(F2, 8'h00, "port2 rising ignored");
    drv2 <= 5'h00;
    repeat (4) @(posedge clock);
    apb(1'b1, F2, 8'hff);
    rdchk(F2, 8'h1f, "port2 falling");
    chk("port2 irq", 32'h1, {31'h0, port2_irq});
    apb(1'b1, F2, 8'he0);
    rdchk(F2, 8'h00, "port2 cleared");
    apb(1'b1, CT, 8'hff);
    rdchk(CT, 8'h7f, "control");
    chk("pad drive", 32'h1, {31'h0, pad_drive_max});
    apb(1'b0, 8'h00, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, slv});
    finish_test();
  end
endmodule
